// ==== sob_option_banks.sv ====
/*
  sob_option_banks: apb register bank holding option banks two to four and
  decoding them into the settings used by sensing, swipe and timer logic.
  assumes: pclk at 125 MHz, asynchronous active-low reset, an apb master that
  holds its request until pready; ic type (swipe or normal) and capacitance
  technology arrive from logic on the same clock.
*/
// How it works
// - bank 2 bit 7 turns the mains filter on, in either layout
// - swipe layout bit 6: 0 gives a level touch pin, 1 a pulse
// - bit 5 doubles charge rate: 500k/1M self, 1M/2M mutual
// - swipe bit 4: swipe state must persist one or two samples
// - swipe bit 3 ends a swipe when all channels go zero
// - swipe bit 2 allows all-zero states inside a swipe
// - swipe bits 1:0 pick single, bidirectional, directional or dual style
// - normal layout bits 0..2 make channel outputs toggle per touch
// - bank 3 bit 3 restarts auto-off on touch (0) or proximity (1)
// - bank 3 bit 2 low enables advanced auto-off
// - bank 3 bit 1 picks tuning targets 320/160 or 640/320
// - bank 3 bit 0 picks calibration base 50 or 100
// - bank 4 bit 3 enables the debug serial port, event mode by default
`timescale 1ns/1ps
`default_nettype none
module sob_option_banks
  import sob_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // context from the rest of the chip
  input  wire logic        swipe_type,
  input  wire logic        mutual_cap,
  // decoded settings
  output logic             mains_filter_enable,
  output logic             touch_pin_pulse_select,
  output logic             charge_rate_select,
  output logic [11:0]      charge_rate_khz,
  output logic [1:0]       min_state_samples,
  output logic             zero_end_enable,
  output logic             zero_state_allow,
  output logic [1:0]       gesture_style,
  output logic             first_output_latch_mode,
  output logic             second_output_latch_mode,
  output logic             third_output_latch_mode,
  output logic             autooff_restart_source,
  output logic             advanced_autooff_disable,
  output logic             autooff_active,
  output logic             tuning_target_select,
  output logic [9:0]       tuning_target_prox,
  output logic [9:0]       tuning_target_touch,
  output logic             tuning_base_select,
  output logic [6:0]       tuning_base,
  output logic             debug_port_enable,
  output logic             debug_event_mode
);

  logic [7:0] swipe_q, tune_q, debug_q;
  logic       event_mode_q;   // 0 = event-driven reporting
  logic       ro_hit_q;       // sticky: write tried to change a system-use bit

  // apb decode; one-cycle access phase, zero wait states
  wire        acc      = psel & penable;
  wire        wr_en    = acc & pwrite & pstrb[0];
  wire        hit_sw   = (paddr == SOB_OFF_SWIPE);
  wire        hit_tu   = (paddr == SOB_OFF_TUNE);
  wire        hit_db   = (paddr == SOB_OFF_DEBUG);
  wire        hit_md   = (paddr == SOB_OFF_MODE);
  wire        hit_st   = (paddr == SOB_OFF_STATUS);
  wire        mapped   = hit_sw | hit_tu | hit_db | hit_md | hit_st;
  wire [7:0]  wbyte    = pwdata[7:0];
  // system-use bits keep their stored value whatever is written
  wire [7:0]  tune_d   = (tune_q & SOB_SYS_TUNE) | (wbyte & ~SOB_SYS_TUNE);
  wire [7:0]  debug_d  = (debug_q & SOB_SYS_DEBUG) | (wbyte & ~SOB_SYS_DEBUG);
  wire        sys_poke = wr_en & ((hit_tu & |((wbyte ^ tune_q) & SOB_SYS_TUNE)) |
                                  (hit_db & |((wbyte ^ debug_q) & SOB_SYS_DEBUG)));

  wire [7:0]  rd_mux = hit_sw ? swipe_q :
                       hit_tu ? tune_q :
                       hit_db ? debug_q :
                       hit_md ? {7'h00, event_mode_q} :
                       hit_st ? {5'h00, ro_hit_q, swipe_type, mutual_cap} : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swipe_q      <= SOB_RST_SWIPE;
      tune_q       <= SOB_RST_TUNE;
      debug_q      <= SOB_RST_DEBUG;
      event_mode_q <= SOB_RST_MODE;
      ro_hit_q     <= 1'b0;
    end else begin
      if (wr_en && hit_sw) swipe_q <= wbyte;
      if (wr_en && hit_tu) tune_q <= tune_d;
      if (wr_en && hit_db) debug_q <= debug_d;
      if (wr_en && hit_md) event_mode_q <= wbyte[0];
      // a new poke wins over the write-one clear of the same cycle
      if (sys_poke) ro_hit_q <= 1'b1;
      else if (wr_en && hit_st && wbyte[2]) ro_hit_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_mux} : 32'h0000_0000;
    end
  end

  // decoding of the banks
  wire        f_mains  = swipe_q[SOB_B_MAINS];
  wire        f_pulse  = swipe_type & swipe_q[SOB_B_PULSE];
  wire        f_rate   = swipe_q[SOB_B_RATE];
  wire [11:0] f_khz    = mutual_cap ? (f_rate ? SOB_RATE_KHZ_MUT_HI : SOB_RATE_KHZ_MUT_LO)
                                    : (f_rate ? SOB_RATE_KHZ_MUT_LO : SOB_RATE_KHZ_SELF_LO);
  wire [1:0]  f_min    = (swipe_type & swipe_q[SOB_B_MINST]) ? SOB_SAMPLES_TWO
                                                             : SOB_SAMPLES_ONE;
  wire        f_zend   = swipe_type & swipe_q[SOB_B_ZEND];
  wire        f_zallow = swipe_type & swipe_q[SOB_B_ZALLOW];
  wire [1:0]  f_style  = swipe_type ? swipe_q[SOB_B_STYLE +: 2] : 2'h0;
  // toggles share bits 2:0 with the swipe fields, so they read zero in swipe types
  wire [2:0]  f_tog    = swipe_type ? 3'h0 : swipe_q[2:0];
  wire        f_aaodis = tune_q[SOB_B_AAODIS];
  wire        f_tgt    = tune_q[SOB_B_TARGET];
  wire        f_base   = tune_q[SOB_B_BASE];
  wire        f_dbg    = debug_q[SOB_B_DBG];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mains_filter_enable      <= 1'b0;
      touch_pin_pulse_select   <= 1'b0;
      charge_rate_select       <= 1'b0;
      charge_rate_khz          <= SOB_RATE_KHZ_SELF_LO;
      min_state_samples        <= SOB_SAMPLES_ONE;
      zero_end_enable          <= 1'b0;
      zero_state_allow         <= 1'b0;
      gesture_style            <= 2'h0;
      first_output_latch_mode  <= 1'b0;
      second_output_latch_mode <= 1'b0;
      third_output_latch_mode  <= 1'b0;
      autooff_restart_source   <= 1'b0;
      advanced_autooff_disable <= 1'b0;
      autooff_active           <= 1'b1;
      tuning_target_select     <= 1'b0;
      tuning_target_prox       <= SOB_TGT_PROX_LO;
      tuning_target_touch      <= SOB_TGT_TOUCH_LO;
      tuning_base_select       <= 1'b0;
      tuning_base              <= SOB_BASE_LO;
      debug_port_enable        <= 1'b0;
      debug_event_mode         <= 1'b0;
    end else begin
      mains_filter_enable      <= f_mains;
      touch_pin_pulse_select   <= f_pulse;
      charge_rate_select       <= f_rate;
      charge_rate_khz          <= f_khz;
      min_state_samples        <= f_min;
      zero_end_enable          <= f_zend;
      zero_state_allow         <= f_zallow;
      gesture_style            <= f_style;
      first_output_latch_mode  <= f_tog[0];
      second_output_latch_mode <= f_tog[1];
      third_output_latch_mode  <= f_tog[2];
      autooff_restart_source   <= tune_q[SOB_B_RESTART];
      advanced_autooff_disable <= f_aaodis;
      autooff_active           <= ~f_aaodis;
      tuning_target_select     <= f_tgt;
      tuning_target_prox       <= f_tgt ? SOB_TGT_PROX_HI : SOB_TGT_PROX_LO;
      tuning_target_touch      <= f_tgt ? SOB_TGT_TOUCH_HI : SOB_TGT_TOUCH_LO;
      tuning_base_select       <= f_base;
      tuning_base              <= f_base ? SOB_BASE_HI : SOB_BASE_LO;
      debug_port_enable        <= f_dbg;
      // event-driven only while the port is on and software has not picked streaming
      debug_event_mode         <= f_dbg & ~event_mode_q;
    end
  end

  // assertions
  property p_mains;
    @(posedge pclk) disable iff (!presetn)
      $changed(swipe_q[SOB_B_MAINS]) |=> mains_filter_enable == $past(swipe_q[SOB_B_MAINS]);
  endproperty
  a_mains: assert property (p_mains) else $error("mains filter not following bank bit");

  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
      ##1 touch_pin_pulse_select == ($past(swipe_q[SOB_B_PULSE]) & $past(swipe_type));
  endproperty
  a_pulse: assert property (p_pulse) else $error("pin pulse select wrong");

  property p_rate;
    @(posedge pclk) disable iff (!presetn)
      ##1 charge_rate_khz == ($past(mutual_cap) ? ($past(f_rate) ? 12'h7D0 : 12'h3E8)
                                                : ($past(f_rate) ? 12'h3E8 : 12'h1F4));
  endproperty
  a_rate: assert property (p_rate) else $error("charge rate wrong");

  property p_min;
    @(posedge pclk) disable iff (!presetn)
      (swipe_type && swipe_q[SOB_B_MINST]) [*2] |-> min_state_samples == 2'h2;
  endproperty
  a_min: assert property (p_min) else $error("min state samples wrong");

  property p_zero;
    @(posedge pclk) disable iff (!presetn)
      !$past(swipe_type) |-> !zero_end_enable && !zero_state_allow;
  endproperty
  a_zero: assert property (p_zero) else $error("zero options active in normal type");

  property p_zallow;
    @(posedge pclk) disable iff (!presetn)
      ##1 zero_state_allow == ($past(swipe_type) & $past(swipe_q[SOB_B_ZALLOW]));
  endproperty
  a_zallow: assert property (p_zallow) else $error("zero state allow wrong");

  property p_style;
    @(posedge pclk) disable iff (!presetn)
      $past(swipe_type) |-> gesture_style == $past(swipe_q[1:0]);
  endproperty
  a_style: assert property (p_style) else $error("gesture style wrong");

  property p_tog;
    @(posedge pclk) disable iff (!presetn)
      $past(swipe_type) |-> !(first_output_latch_mode || second_output_latch_mode || third_output_latch_mode);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle active in swipe type");

  property p_aao;
    @(posedge pclk) disable iff (!presetn)
      ##1 advanced_autooff_disable == $past(tune_q[SOB_B_AAODIS])
          && autooff_active == !$past(tune_q[SOB_B_AAODIS]);
  endproperty
  a_aao: assert property (p_aao) else $error("auto-off polarity wrong");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      ##1 autooff_restart_source == $past(tune_q[SOB_B_RESTART]);
  endproperty
  a_restart: assert property (p_restart) else $error("auto-off restart source wrong");

  property p_tgt;
    @(posedge pclk) disable iff (!presetn)
      ##1 tuning_target_prox == ($past(f_tgt) ? 10'h280 : 10'h140)
          && tuning_target_touch == ($past(f_tgt) ? 10'h140 : 10'h0A0);
  endproperty
  a_tgt: assert property (p_tgt) else $error("tuning target wrong");

  property p_base;
    @(posedge pclk) disable iff (!presetn)
      ##1 tuning_base == ($past(f_base) ? 7'h64 : 7'h32);
  endproperty
  a_base: assert property (p_base) else $error("tuning base wrong");

  property p_dbg;
    @(posedge pclk) disable iff (!presetn)
      ##1 debug_event_mode == ($past(debug_q[SOB_B_DBG]) & !$past(event_mode_q))
          && debug_port_enable == $past(debug_q[SOB_B_DBG]);
  endproperty
  a_dbg: assert property (p_dbg) else $error("event mode without debug port");

  property p_sys;
    @(posedge pclk) disable iff (!presetn)
      ##1 (tune_q & 8'hF0) == ($past(tune_q) & 8'hF0);
  endproperty
  a_sys: assert property (p_sys) else $error("system-use bits changed");

endmodule // sob_option_banks
`default_nettype wire

// ==== sob_pkg.sv ====
/*
  sob_pkg: register offsets, field positions, reset values and decoded constants
  for the option banks two to four.
  assumes: an apb slave with 32-bit data and one aligned word per register.
*/
`default_nettype none
package sob_pkg;
  // byte offsets
  localparam logic [7:0] SOB_OFF_SWIPE  = 8'h00;
  localparam logic [7:0] SOB_OFF_TUNE   = 8'h04;
  localparam logic [7:0] SOB_OFF_DEBUG  = 8'h08;
  localparam logic [7:0] SOB_OFF_MODE   = 8'h0C;
  localparam logic [7:0] SOB_OFF_STATUS = 8'h10;
  // reset values
  localparam logic [7:0] SOB_RST_SWIPE  = 8'h00;
  localparam logic [7:0] SOB_RST_TUNE   = 8'h00;
  localparam logic [7:0] SOB_RST_DEBUG  = 8'h00;
  localparam logic       SOB_RST_MODE   = 1'b0;
  // field positions in the swipe/touch bank
  localparam int SOB_B_MAINS   = 7;
  localparam int SOB_B_PULSE   = 6;
  localparam int SOB_B_RATE    = 5;
  localparam int SOB_B_MINST   = 4;
  localparam int SOB_B_ZEND    = 3;
  localparam int SOB_B_ZALLOW  = 2;
  localparam int SOB_B_STYLE   = 0;
  // field positions in the tuning and debug banks
  localparam int SOB_B_RESTART = 3;
  localparam int SOB_B_AAODIS  = 2;
  localparam int SOB_B_TARGET  = 1;
  localparam int SOB_B_BASE    = 0;
  localparam int SOB_B_DBG     = 3;
  // system-use bits that software may not change
  localparam logic [7:0] SOB_SYS_TUNE  = 8'hF0;
  localparam logic [7:0] SOB_SYS_DEBUG = 8'hF7;
  // decoded figures
  localparam logic [11:0] SOB_RATE_KHZ_SELF_LO = 12'h1F4;
  localparam logic [11:0] SOB_RATE_KHZ_MUT_LO  = 12'h3E8;
  localparam logic [11:0] SOB_RATE_KHZ_MUT_HI  = 12'h7D0;
  localparam logic [9:0]  SOB_TGT_PROX_LO      = 10'h140;
  localparam logic [9:0]  SOB_TGT_PROX_HI      = 10'h280;
  localparam logic [9:0]  SOB_TGT_TOUCH_LO     = 10'h0A0;
  localparam logic [9:0]  SOB_TGT_TOUCH_HI     = 10'h140;
  localparam logic [6:0]  SOB_BASE_LO          = 7'h32;
  localparam logic [6:0]  SOB_BASE_HI          = 7'h64;
  localparam logic [1:0]  SOB_SAMPLES_ONE      = 2'h1;
  localparam logic [1:0]  SOB_SAMPLES_TWO      = 2'h2;
  typedef enum logic [1:0] {
    SOB_STYLE_SINGLE, SOB_STYLE_BIDIR, SOB_STYLE_DIRECTIONAL, SOB_STYLE_DUAL
  } sob_style_t;
endpackage
`default_nettype wire

// ==== sob_option_banks_tb_top.sv ====
/*
  sob_option_banks_tb_top: self-checking bench for the option bank register block.
  assumes: zero-wait apb slave, decoded outputs follow the stored banks one edge later.
*/
`timescale 1ns/1ps
`default_nettype none
module sob_option_banks_tb_top import sob_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, swipe_type, mutual_cap;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        mains_filter_enable, touch_pin_pulse_select, charge_rate_select, zero_end_enable;
  logic        zero_state_allow, first_output_latch_mode, second_output_latch_mode, third_output_latch_mode;
  logic        autooff_restart_source, advanced_autooff_disable, autooff_active, tuning_target_select;
  logic        tuning_base_select, debug_port_enable, debug_event_mode;
  logic [11:0] charge_rate_khz;
  logic [1:0]  min_state_samples, gesture_style;
  logic [9:0]  tuning_target_prox, tuning_target_touch;
  logic [6:0]  tuning_base;
  logic [7:0]  vals [11] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h00, 8'h01, 8'h02, 8'h03, 8'hFF};
  int          err_count = 0, cmp_count = 0, cyc = 0;

  sob_option_banks i_sob_option_banks (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .swipe_type(swipe_type), .mutual_cap(mutual_cap),
    .mains_filter_enable(mains_filter_enable), .touch_pin_pulse_select(touch_pin_pulse_select),
    .charge_rate_select(charge_rate_select), .charge_rate_khz(charge_rate_khz),
    .min_state_samples(min_state_samples), .zero_end_enable(zero_end_enable),
    .zero_state_allow(zero_state_allow), .gesture_style(gesture_style),
    .first_output_latch_mode(first_output_latch_mode), .second_output_latch_mode(second_output_latch_mode),
    .third_output_latch_mode(third_output_latch_mode), .autooff_restart_source(autooff_restart_source),
    .advanced_autooff_disable(advanced_autooff_disable), .autooff_active(autooff_active),
    .tuning_target_select(tuning_target_select), .tuning_target_prox(tuning_target_prox),
    .tuning_target_touch(tuning_target_touch), .tuning_base_select(tuning_base_select),
    .tuning_base(tuning_base), .debug_port_enable(debug_port_enable), .debug_event_mode(debug_event_mode));

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; pready and the answer are taken at the rising edge that ends the access phase
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(negedge pclk);
  endtask

  task automatic check_b2(input logic [7:0] v, input logic s, input logic m);
    check("mains", 32'(mains_filter_enable), 32'(v[7]));
    check("pulse", 32'(touch_pin_pulse_select), 32'(v[6] & s));
    check("rate_sel", 32'(charge_rate_select), 32'(v[5]));
    check("rate_khz", 32'(charge_rate_khz), m ? (v[5] ? 32'h7D0 : 32'h3E8) : (v[5] ? 32'h3E8 : 32'h1F4));
    check("min_state", 32'(min_state_samples), (s & v[4]) ? 32'h2 : 32'h1);
    check("zero_end", 32'(zero_end_enable), 32'(v[3] & s));
    check("zero_allow", 32'(zero_state_allow), 32'(v[2] & s));
    check("style", 32'(gesture_style), s ? 32'(v[1:0]) : 32'h0);
    check("latch", 32'({third_output_latch_mode, second_output_latch_mode, first_output_latch_mode}),
          s ? 32'h0 : 32'(v[2:0]));
  endtask

  task automatic check_b3(input logic [7:0] v);
    check("restart", 32'(autooff_restart_source), 32'(v[3]));
    check("aao_dis", 32'(advanced_autooff_disable), 32'(v[2]));
    check("aao_act", 32'(autooff_active), 32'(!v[2]));
    check("tgt_sel", 32'(tuning_target_select), 32'(v[1]));
    check("tgt_prox", 32'(tuning_target_prox), v[1] ? 32'h280 : 32'h140);
    check("tgt_touch", 32'(tuning_target_touch), v[1] ? 32'h140 : 32'hA0);
    check("base_sel", 32'(tuning_base_select), 32'(v[0]));
    check("base", 32'(tuning_base), v[0] ? 32'h64 : 32'h32);
  endtask

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // a hang ends the run as a mismatch
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, swipe_type, mutual_cap} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    @(negedge pclk);
    check_b2(8'h00, 1'b0, 1'b0);
    check_b3(8'h00);
    check("dbg_rst", 32'({debug_port_enable, debug_event_mode}), 32'h0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge pclk);
        swipe_type <= k[1];
        mutual_cap <= k[0];
        apb(1'b1, SOB_OFF_SWIPE, 32'(vals[i]), 4'hF);
        settle();
        check_b2(vals[i], k[1], k[0]);
        apb(1'b0, SOB_OFF_STATUS, 32'h0, 4'h0);
        check("status", rd, 32'(k[1:0]));
      end
    end
    apb(1'b1, SOB_OFF_SWIPE, 32'h55, 4'hE);
    apb(1'b0, SOB_OFF_SWIPE, 32'h0, 4'h0);
    check("strb_off", rd, 32'hFF);
    // system-use bits kept clear in normal programming
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, SOB_OFF_TUNE, 32'(i), 4'hF);
      settle();
      check_b3(8'(i));
      apb(1'b0, SOB_OFF_TUNE, 32'h0, 4'h0);
      check("b3_read", rd, 32'(i));
    end
    apb(1'b1, SOB_OFF_TUNE, 32'hFA, 4'hF);
    apb(1'b0, SOB_OFF_TUNE, 32'h0, 4'h0);
    check("b3_sys", rd, 32'h0A);
    apb(1'b0, SOB_OFF_STATUS, 32'h0, 4'h0);
    check("sticky", rd, 32'h7);
    apb(1'b1, SOB_OFF_STATUS, 32'h4, 4'hF);
    apb(1'b1, SOB_OFF_DEBUG, 32'h08, 4'hF);
    settle();
    check("dbg_on", 32'({debug_port_enable, debug_event_mode}), 32'h3);
    apb(1'b1, SOB_OFF_MODE, 32'h1, 4'hF);
    settle();
    check("dbg_stream", 32'({debug_port_enable, debug_event_mode}), 32'h2);
    apb(1'b1, SOB_OFF_DEBUG, 32'hFF, 4'hF);
    apb(1'b0, SOB_OFF_DEBUG, 32'h0, 4'h0);
    check("b4_sys", rd, 32'h08);
    apb(1'b0, SOB_OFF_STATUS, 32'h0, 4'h0);
    check("sticky4", rd, 32'h7);
    apb(1'b1, SOB_OFF_DEBUG, 32'h0, 4'hF);
    settle();
    check("dbg_off", 32'(debug_port_enable), 32'h0);
    // unmapped place answers with an error and zero data
    apb(1'b1, 8'h14, 32'hFF, 4'hF);
    check("unm_wr_err", 32'(serr), 32'h1);
    apb(1'b0, 8'h14, 32'h0, 4'h0);
    check("unm_rd", {rd[30:0], serr}, 32'h1);
    tally_and_finish();
  end
endmodule // sob_option_banks_tb_top
`default_nettype wire
